/* File: rtl/rprc_delay_cnt.sv */
// Down counter that flags when a loaded cycle count has run out
module rprc_delay_cnt
    import rprc_pkg::*;
(
    // Clock and reset
    input  wire logic             ref_clk,
    input  wire logic             reset_n,
    // Control
    input  wire logic             load,
    input  wire logic [CNT_W-1:0] load_value,
    input  wire logic             run,
    // Status
    output logic                  done
);

    typedef struct packed {
        logic [CNT_W-1:0] count;
        logic             done;
    } rprc_cnt_t;

    rprc_cnt_t cur;
    rprc_cnt_t next_cur;

    // Load wins over counting so a restart is never half-applied
    always_comb begin
        next_cur = cur;
        if (load) begin
            next_cur.count = load_value;
            next_cur.done  = 1'b0;
        end else if (run && !cur.done) begin
            if (cur.count <= CNT_W'(1)) begin
                next_cur.count = '0;
                next_cur.done  = 1'b1;
            end else begin
                next_cur.count = cur.count - CNT_W'(1);
            end
        end
    end

    // State register
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign done = cur.done;

endmodule // rprc_delay_cnt

/* File: rtl/rprc_pkg.sv */
// Package of timing constants and state encoding for the radio power and reset control
package rprc_pkg;

    // ------------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_MHZ        = 200;
    localparam int unsigned POR_HOLD_MS    = 110;     // Longest power-on reset hold
    localparam int unsigned HOST_WAIT_MS   = 150;     // Least wait before host bus access
    // Longest time rounds down, least time rounds up (whole ms give exact counts)
    localparam longint unsigned POR_HOLD_CYC  = 64'(POR_HOLD_MS) * 64'(CLK_MHZ) * 64'd1000;
    localparam longint unsigned HOST_WAIT_CYC = 64'(HOST_WAIT_MS) * 64'(CLK_MHZ) * 64'd1000;
    localparam int unsigned CNT_W          = 26;      // Holds 30,000,000 cycles

    // ------------------------------------------------------------------
    // Sequencer states, Gray coded along the power-up path
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        RPRC_OFF   = 2'b00,   // Supplies absent
        RPRC_POR   = 2'b01,   // Power-on reset held
        RPRC_READY = 2'b11,   // Released, waiting out the host wait
        RPRC_BUS   = 2'b10    // Host access window open
    } rprc_state_t;

endpackage : rprc_pkg

/* File: rtl/rprc_top.sv */
// Power and reset control for a dual-radio device: regulators, section resets, power-on reset
//
// Notes on behaviour
// - WLAN request high keeps regulators on and, once power-on reset is released, WLAN section out of reset.
// - WLAN request low holds the WLAN section in reset.
// - Regulator enable is the OR of both power requests.
// - Both requests low turns the regulators off.
// - Short-range request low with WLAN request high holds short-range section in reset.
// - Power-on reset lasts at most 110 ms after both supplies are good.
module rprc_top
    import rprc_pkg::*;
#(
    parameter logic [CNT_W-1:0] POR_CYCLES  = CNT_W'(POR_HOLD_CYC),
    parameter logic [CNT_W-1:0] WAIT_CYCLES = CNT_W'(HOST_WAIT_CYC)
)
(
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic reset_n,
    // Supply monitors, high once above the power-on threshold
    input  wire logic core_supply,
    input  wire logic io_supply,
    // Host power requests
    input  wire logic wlan_power_request,
    input  wire logic shortrange_power_request,
    // Power and reset controls
    output logic      regulator_enable,
    output logic      por_reset_n,
    output logic      wlan_reset_n,
    output logic      shortrange_reset_n,
    // Status
    output logic      host_access_ok
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        rprc_state_t state;
        logic        reg_en;
        logic        por_n;
        logic        wlan_n;
        logic        sr_n;
        logic        access_ok;
    } rprc_top_t;

    rprc_top_t cur;
    rprc_top_t next_cur;

    // ------------------------------------------------------------------
    // Timer loads
    // ------------------------------------------------------------------
    // Difference floored at one, so a short or misordered setting never loads zero
    function automatic logic [CNT_W-1:0] rprc_sat_sub(input logic [CNT_W-1:0] a,
                                                      input logic [CNT_W-1:0] b);
        return (a > b) ? a - b : CNT_W'(1);
    endfunction

    // Loading the timer and stepping the state take two edges of their own,
    // so they come off the hold to keep the release inside the limit
    localparam logic [CNT_W-1:0] POR_LOAD  = rprc_sat_sub(POR_CYCLES, CNT_W'(2));
    // Host wait runs from supplies good; the hold already spent comes off it
    localparam logic [CNT_W-1:0] WAIT_LOAD = rprc_sat_sub(WAIT_CYCLES, POR_CYCLES);

    logic             supplies_good;
    logic             cnt_load;
    logic [CNT_W-1:0] cnt_value;
    logic             cnt_done;

    assign supplies_good = core_supply && io_supply;

    // Shared timer: power-on hold, then the host wait
    rprc_delay_cnt u_timer (
        .ref_clk    (ref_clk),
        .reset_n    (reset_n),
        .load       (cnt_load),
        .load_value (cnt_value),
        .run        (1'b1),
        .done       (cnt_done)
    );

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        next_cur  = cur;
        cnt_load  = 1'b0;
        // Default load is the hold, so the supply edge needs no value of its own
        cnt_value = POR_LOAD;
        case (cur.state)
            RPRC_OFF: begin
                if (supplies_good) begin
                    next_cur.state = RPRC_POR;
                    cnt_load       = 1'b1;
                end
            end
            RPRC_POR: begin
                // The shortened load puts this edge exactly on the hold limit
                if (cnt_done) begin
                    next_cur.state = RPRC_READY;
                    cnt_load       = 1'b1;
                    // Same timer reused for the host wait, saving a second counter
                    cnt_value      = WAIT_LOAD;
                end
            end
            RPRC_READY: begin
                if (cnt_done) begin
                    next_cur.state = RPRC_BUS;
                end
            end
            RPRC_BUS: begin
                next_cur.state = RPRC_BUS;
            end
            default: begin
                next_cur.state = RPRC_OFF;
            end
        endcase
        // Losing either supply drops straight back to reset
        if (!supplies_good) begin
            next_cur.state = RPRC_OFF;
        end
        next_cur.por_n     = (next_cur.state == RPRC_READY) || (next_cur.state == RPRC_BUS);
        next_cur.access_ok = (next_cur.state == RPRC_BUS);
        // Requests are plain levels; any later assertion is accepted as well
        next_cur.reg_en = wlan_power_request || shortrange_power_request;
        next_cur.wlan_n = next_cur.por_n && wlan_power_request;
        next_cur.sr_n   = next_cur.por_n && shortrange_power_request;
    end

    // State register; all outputs come from here
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            cur <= '{state: RPRC_OFF, default: 1'b0};
        end else begin
            cur <= next_cur;
        end
    end

    assign regulator_enable   = cur.reg_en;
    assign por_reset_n        = cur.por_n;
    assign wlan_reset_n       = cur.wlan_n;
    assign shortrange_reset_n = cur.sr_n;
    assign host_access_ok     = cur.access_ok;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    // Long hold checked by a helper counter of cycles spent in reset with supplies good
    logic [CNT_W:0] por_age;
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            por_age <= '0;
        end else if (!supplies_good || cur.por_n) begin
            por_age <= '0;
        end else begin
            por_age <= por_age + (CNT_W+1)'(1);
        end
    end

    // Cycles with both supplies good, saturating; the host wait is timed against it
    logic [CNT_W:0] sup_age;
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            sup_age <= '0;
        end else if (!supplies_good) begin
            sup_age <= '0;
        end else if (sup_age != '1) begin
            sup_age <= sup_age + (CNT_W+1)'(1);
        end
    end

    AST_REG_OR: assert property (@(posedge ref_clk) disable iff (!reset_n)
        ##1 regulator_enable == $past(wlan_power_request || shortrange_power_request))
        else $error("regulator enable is not the OR of the requests");

    AST_REG_OFF: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (!wlan_power_request && !shortrange_power_request) |=> !regulator_enable)
        else $error("regulators on with both requests low");

    AST_WLAN_ON: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (wlan_power_request && por_reset_n && supplies_good)
            |=> (wlan_reset_n && regulator_enable))
        else $error("wlan held in reset while requested");

    AST_WLAN_RST: assert property (@(posedge ref_clk) disable iff (!reset_n)
        !wlan_power_request |=> !wlan_reset_n)
        else $error("wlan out of reset with request low");

    AST_SR_RST: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (!shortrange_power_request && wlan_power_request) |=> !shortrange_reset_n)
        else $error("short-range out of reset with request low");

    AST_POR_MAX: assert property (@(posedge ref_clk) disable iff (!reset_n)
        por_age <= {1'b0, POR_CYCLES})
        else $error("power-on reset held too long");

    AST_POR_RELEASE: assert property (@(posedge ref_clk) disable iff (!reset_n)
        $rose(por_reset_n) |-> $past(supplies_good, 2))
        else $error("power-on reset released without supplies");

    AST_ACCESS_AFTER_POR: assert property (@(posedge ref_clk) disable iff (!reset_n)
        host_access_ok |-> (por_reset_n && (sup_age >= {1'b0, WAIT_CYCLES})))
        else $error("host access flagged too early");

    // A supply loss must take back the release and the access flag on the next edge
    AST_SUPPLY_DROP: assert property (@(posedge ref_clk) disable iff (!reset_n)
        !supplies_good |=> (!por_reset_n && !host_access_ok))
        else $error("released state kept after a supply loss");

    COV_WLAN_UP: cover property (@(posedge ref_clk) disable iff (!reset_n)
        $rose(wlan_reset_n));
    COV_SR_ONLY: cover property (@(posedge ref_clk) disable iff (!reset_n)
        regulator_enable && shortrange_reset_n && !wlan_reset_n);
    COV_ACCESS: cover property (@(posedge ref_clk) disable iff (!reset_n)
        $rose(host_access_ok));
    COV_BOTH_UP: cover property (@(posedge ref_clk) disable iff (!reset_n)
        regulator_enable && wlan_reset_n && shortrange_reset_n);
    COV_DROPOUT: cover property (@(posedge ref_clk) disable iff (!reset_n)
        $fell(por_reset_n));

endmodule // rprc_top

/* File: tb/rprc_host_model.sv */
// Host-side model that drives the two power-request inputs of the sequencer
module rprc_host_model (
    // Clock
    input  wire logic ref_clk,
    // Wishes of the bench
    input  wire logic want_wlan,
    input  wire logic want_sr,
    // Requests to the device
    output logic      wlan_power_request,
    output logic      shortrange_power_request
);
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------------
    // Request drivers
    // ------------------------------------------------------------------
    // Low from time zero, before any supply is up, as a careful host would
    initial begin
        wlan_power_request       = 1'b0;
        shortrange_power_request = 1'b0;
    end

    // Levels move only on the falling edge, a cycle after the wish.
    // The host never rushes: every delay it adds only lengthens the sequence
    always @(negedge ref_clk) begin
        wlan_power_request       <= want_wlan;
        shortrange_power_request <= want_sr;
    end
endmodule // rprc_host_model

/* File: tb/tb.sv */
// Self-checking testbench for the radio power and reset control
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import rprc_pkg::*;

    localparam int POR = 20;  // Shortened power-on hold
    localparam int WT  = 30;  // Shortened host wait
    logic ref_clk = 1'b0, reset_n = 1'b0, core_supply = 1'b0, io_supply = 1'b0;
    logic want_wlan = 1'b0, want_sr = 1'b0, wlan_power_request, shortrange_power_request;
    logic regulator_enable, por_reset_n, wlan_reset_n, shortrange_reset_n, host_access_ok;
    logic [2:0]  e;
    logic [31:0] rng = 32'h26;
    int          mismatches = 0;
    int          checks = 0;

    // ------------------------------------------------------------------
    // Clock, design and host
    // ------------------------------------------------------------------
    // Free-running 200 MHz clock
    always #2.5 ref_clk = ~ref_clk;

    rprc_top #(.POR_CYCLES(CNT_W'(POR)), .WAIT_CYCLES(CNT_W'(WT))) i_dut (
        .ref_clk(ref_clk), .reset_n(reset_n), .core_supply(core_supply),
        .io_supply(io_supply), .wlan_power_request(wlan_power_request),
        .shortrange_power_request(shortrange_power_request),
        .regulator_enable(regulator_enable), .por_reset_n(por_reset_n),
        .wlan_reset_n(wlan_reset_n), .shortrange_reset_n(shortrange_reset_n),
        .host_access_ok(host_access_ok));

    rprc_host_model i_host (.ref_clk(ref_clk), .want_wlan(want_wlan), .want_sr(want_sr),
        .wlan_power_request(wlan_power_request),
        .shortrange_power_request(shortrange_power_request));

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Repeatable xorshift stream
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        x = x ^ (x << 5);
        return x;
    endfunction

    // Regulator, WLAN release, short-range release once powered up
    function automatic logic [2:0] expect_out(input logic w, input logic s);
        return {w | s, w, s};
    endfunction

    task automatic check(input logic seen, input logic exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    task automatic test_done();
        if (mismatches == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    initial begin
        cyc(8);
        reset_n <= 1'b1;
        want_wlan <= 1'b1;
        want_sr <= 1'b1;
        cyc(2);
        // Requests before supplies: regulators on, sections still held
        check(regulator_enable, 1'b1);
        check(wlan_reset_n, 1'b0);
        core_supply <= 1'b1;
        io_supply <= 1'b1;
        cyc(POR - 1);
        check(por_reset_n, 1'b0);
        cyc(1);
        check(por_reset_n, 1'b1);
        check(wlan_reset_n, 1'b1);
        check(host_access_ok, 1'b0);
        cyc(WT - POR);
        check(host_access_ok, 1'b0);
        cyc(1);
        check(host_access_ok, 1'b1);
        // Every combination first, then random back-to-back levels
        for (int i = 0; i < 204; i++) begin
            rng = xs(rng);
            want_wlan <= (i < 4) ? i[1] : rng[0];
            want_sr <= (i < 4) ? i[0] : rng[1];
            cyc(2);
            e = expect_out(want_wlan, want_sr);
            check(regulator_enable, e[2]);
            check(wlan_reset_n, e[1]);
            check(shortrange_reset_n, e[0]);
        end
        // Supply dropout in mid-run restarts the power-on hold
        want_wlan <= 1'b1;
        cyc(2);
        io_supply <= 1'b0;
        cyc(1);
        check(por_reset_n, 1'b0);
        check(wlan_reset_n, 1'b0);
        check(host_access_ok, 1'b0);
        io_supply <= 1'b1;
        // Restarted hold and host wait keep the power-up cycle counts
        cyc(POR - 1);
        check(por_reset_n, 1'b0);
        cyc(1);
        check(por_reset_n, 1'b1);
        cyc(WT - POR);
        check(host_access_ok, 1'b0);
        cyc(1);
        check(host_access_ok, 1'b1);
        test_done();
    end

    // Cut a hang short well beyond the expected run of about 480 cycles
    initial begin
        #20000;
        mismatches++;
        test_done();
    end
endmodule // tb
